// File: rca_consts.vh
// shared constants for the registered cascadable 16-bit alu
`ifndef RCA_CONSTS_VH
`define RCA_CONSTS_VH

`define RCA_WIDTH 16
`define RCA_AXI_AW 4
`define RCA_AXI_DW 32

// function select codes
`define RCA_FN_CLEAR 3'h0
`define RCA_FN_BMINA 3'h1
`define RCA_FN_AMINB 3'h2
`define RCA_FN_ADD 3'h3
`define RCA_FN_XOR 3'h4
`define RCA_FN_OR 3'h5
`define RCA_FN_AND 3'h6
`define RCA_FN_PRESET 3'h7

// register byte offsets
`define RCA_OFF_CTRL 4'h0
`define RCA_OFF_OPND 4'h4
`define RCA_OFF_CAPT 4'h8
`define RCA_OFF_STAT 4'hc

// control register layout
`define RCA_CTRL_W 9
`define RCA_CTRL_FS_LSB 0
`define RCA_CTRL_FS_MSB 2
`define RCA_CTRL_ASEL 3
`define RCA_CTRL_BSEL 4
`define RCA_CTRL_CIN 5
`define RCA_CTRL_INBYP 6
`define RCA_CTRL_OUTBYP 7
`define RCA_CTRL_SWMODE 8
`define RCA_CTRL_RESET 9'h018

// operand register layout
`define RCA_OPND_A_LSB 0
`define RCA_OPND_A_MSB 15
`define RCA_OPND_B_LSB 16
`define RCA_OPND_B_MSB 31
`define RCA_OPND_RESET 32'h0000_0000

// capture strobe register layout
`define RCA_CAPT_W 3
`define RCA_CAPT_A 0
`define RCA_CAPT_B 1
`define RCA_CAPT_F 2
`define RCA_CAPT_RESET 3'h0

// status register layout
`define RCA_STAT_F_LSB 0
`define RCA_STAT_F_MSB 15
`define RCA_STAT_ZERO 16
`define RCA_STAT_COUT 17
`define RCA_STAT_OVF 18
`define RCA_STAT_GN 19
`define RCA_STAT_PN 20

// axi responses
`define RCA_RESP_OKAY 2'h0
`define RCA_RESP_SLVERR 2'h2

`endif

// File: rca_hold_reg.v
// load-enabled holding register with no reset, for operands and result
`timescale 1ns/1ps
`default_nettype none
module rca_hold_reg #(
    parameter WIDTH = 16
) (
    input wire clk_in,
    input wire load_n_in,
    input wire [WIDTH-1:0] d_in,
    output reg [WIDTH-1:0] q_out
);

    // contents are unknown until the first load; there is deliberately no reset
    always @(posedge clk_in) begin
        if (!load_n_in) begin
            q_out <= d_in;
        end
    end

endmodule
`default_nettype wire

// File: rca_alu.v
// combinational 16-bit alu with look-ahead carry and status
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.vh"
module rca_alu #(
    parameter WIDTH = 16
) (
    input wire [WIDTH-1:0] op_a_in,
    input wire [WIDTH-1:0] op_b_in,
    input wire [2:0] fsel_in,
    input wire cin_in,
    output reg [WIDTH-1:0] f_out,
    output wire zero_out,
    output wire cout_out,
    output wire ovf_out,
    output wire g_n_out,
    output wire p_n_out
);

    wire [WIDTH-1:0] a_eff;
    wire [WIDTH-1:0] b_eff;
    wire [WIDTH-1:0] bit_g;
    wire [WIDTH-1:0] bit_p;
    wire [WIDTH-1:0] grp_g;
    wire [WIDTH-1:0] grp_p;
    wire [WIDTH-1:0] carry;
    wire [WIDTH-1:0] sum;

    // subtract forms complement one operand before the adder
    assign a_eff = (fsel_in == `RCA_FN_BMINA) ? ~op_a_in : op_a_in;
    assign b_eff = (fsel_in == `RCA_FN_AMINB) ? ~op_b_in : op_b_in;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign bit_g[i] = a_eff[i] & b_eff[i];
            assign bit_p[i] = a_eff[i] | b_eff[i];
            if (i == 0) begin : g_lsb
                assign grp_p[i] = bit_p[i];
                assign grp_g[i] = bit_g[i];
                assign carry[i] = cin_in;
            end else begin : g_up
                assign grp_p[i] = bit_p[i] & grp_p[i-1];
                assign grp_g[i] = bit_g[i] | (bit_p[i] & grp_g[i-1]);
                assign carry[i] = grp_g[i-1] | (grp_p[i-1] & cin_in);
            end
            assign sum[i] = a_eff[i] ^ b_eff[i] ^ carry[i];
        end
    endgenerate

    // for logic and init codes these still follow the adder equations; meaningless there
    assign cout_out = grp_g[WIDTH-1] | (grp_p[WIDTH-1] & cin_in);
    assign ovf_out = carry[WIDTH-1] ^ cout_out;
    assign g_n_out = ~grp_g[WIDTH-1];
    assign p_n_out = ~grp_p[WIDTH-1];

    always @* begin
        case (fsel_in)
            `RCA_FN_CLEAR: f_out = {WIDTH{1'b0}};
            `RCA_FN_BMINA: f_out = sum;
            `RCA_FN_AMINB: f_out = sum;
            `RCA_FN_ADD: f_out = sum;
            `RCA_FN_XOR: f_out = op_a_in ^ op_b_in;
            `RCA_FN_OR: f_out = op_a_in | op_b_in;
            `RCA_FN_AND: f_out = op_a_in & op_b_in;
            default: f_out = {WIDTH{1'b1}};
        endcase
    end

    assign zero_out = ~(|f_out);

endmodule
`default_nettype wire

// File: rca_top.v
// registered cascadable 16-bit alu with pin control and an axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.vh"
module rca_top (
    input wire CORE_CLK_IN,
    input wire ARST_N_IN,
    input wire [`RCA_WIDTH-1:0] A_IN,
    input wire [`RCA_WIDTH-1:0] B_IN,
    input wire [2:0] FUNCTION_SELECT_IN,
    input wire CARRY_IN_IN,
    input wire A_OPERAND_SELECT_IN,
    input wire B_OPERAND_SELECT_IN,
    input wire OPERAND_A_CAPTURE_N_IN,
    input wire OPERAND_B_CAPTURE_N_IN,
    input wire RESULT_CAPTURE_N_IN,
    input wire INPUT_BYPASS_IN,
    input wire OUTPUT_BYPASS_IN,
    input wire OUTPUT_DRIVE_N_IN,
    output wire [`RCA_WIDTH-1:0] RESULT_OUT,
    output wire RESULT_OE_N_OUT,
    output wire ZERO_FLAG_OUT,
    output wire CARRY_OUT_OUT,
    output wire OVERFLOW_FLAG_OUT,
    output wire GENERATE_N_OUT,
    output wire PROPAGATE_N_OUT,
    input wire [`RCA_AXI_AW-1:0] AWADDR_IN,
    input wire [2:0] AWPROT_IN,
    input wire AWVALID_IN,
    output reg AWREADY_OUT,
    input wire [`RCA_AXI_DW-1:0] WDATA_IN,
    input wire [3:0] WSTRB_IN,
    input wire WVALID_IN,
    output reg WREADY_OUT,
    output reg [1:0] BRESP_OUT,
    output reg BVALID_OUT,
    input wire BREADY_IN,
    input wire [`RCA_AXI_AW-1:0] ARADDR_IN,
    input wire [2:0] ARPROT_IN,
    input wire ARVALID_IN,
    output reg ARREADY_OUT,
    output reg [`RCA_AXI_DW-1:0] RDATA_OUT,
    output reg [1:0] RRESP_OUT,
    output reg RVALID_OUT,
    input wire RREADY_IN
);

    // software-visible state
    reg [`RCA_CTRL_W-1:0] ctrl_q;
    reg [`RCA_AXI_DW-1:0] opnd_q;
    reg [`RCA_CAPT_W-1:0] capt_q;

    // write channel holding state
    reg aw_full_q;
    reg w_full_q;
    reg [`RCA_AXI_AW-1:0] awaddr_q;
    reg [`RCA_AXI_DW-1:0] wdata_q;
    reg [3:0] wstrb_q;

    // control and operand sources: pins, or the control, capture and operand registers while software mode is set
    wire sw_mode = ctrl_q[`RCA_CTRL_SWMODE];
    wire [2:0] fsel = sw_mode ? ctrl_q[`RCA_CTRL_FS_MSB:`RCA_CTRL_FS_LSB] : FUNCTION_SELECT_IN;
    wire cin = sw_mode ? ctrl_q[`RCA_CTRL_CIN] : CARRY_IN_IN;
    wire a_sel = sw_mode ? ctrl_q[`RCA_CTRL_ASEL] : A_OPERAND_SELECT_IN;
    wire b_sel = sw_mode ? ctrl_q[`RCA_CTRL_BSEL] : B_OPERAND_SELECT_IN;
    wire in_byp = sw_mode ? ctrl_q[`RCA_CTRL_INBYP] : INPUT_BYPASS_IN;
    wire out_byp = sw_mode ? ctrl_q[`RCA_CTRL_OUTBYP] : OUTPUT_BYPASS_IN;
    wire cap_a_n = sw_mode ? ~capt_q[`RCA_CAPT_A] : OPERAND_A_CAPTURE_N_IN;
    wire cap_b_n = sw_mode ? ~capt_q[`RCA_CAPT_B] : OPERAND_B_CAPTURE_N_IN;
    wire cap_f_n = sw_mode ? ~capt_q[`RCA_CAPT_F] : RESULT_CAPTURE_N_IN;
    wire [`RCA_WIDTH-1:0] a_src = sw_mode ? opnd_q[`RCA_OPND_A_MSB:`RCA_OPND_A_LSB] : A_IN;
    wire [`RCA_WIDTH-1:0] b_src = sw_mode ? opnd_q[`RCA_OPND_B_MSB:`RCA_OPND_B_LSB] : B_IN;

    // datapath
    wire [`RCA_WIDTH-1:0] a_reg;
    wire [`RCA_WIDTH-1:0] b_reg;
    wire [`RCA_WIDTH-1:0] f_reg;
    wire [`RCA_WIDTH-1:0] alu_f;
    wire alu_zero;
    wire alu_cout;
    wire alu_ovf;
    wire alu_g_n;
    wire alu_p_n;

    // shared clock, no reset on any datapath register
    rca_hold_reg #(.WIDTH(`RCA_WIDTH)) u_reg_a (
        .clk_in(CORE_CLK_IN),
        .load_n_in(cap_a_n),
        .d_in(a_src),
        .q_out(a_reg)
    );

    rca_hold_reg #(.WIDTH(`RCA_WIDTH)) u_reg_b (
        .clk_in(CORE_CLK_IN),
        .load_n_in(cap_b_n),
        .d_in(b_src),
        .q_out(b_reg)
    );

    // registers keep loading whatever the bypass state
    wire [`RCA_WIDTH-1:0] a_path = in_byp ? a_src : a_reg;
    wire [`RCA_WIDTH-1:0] b_path = in_byp ? b_src : b_reg;

    // feedback taps the result register, never the pin mux, so accumulation survives output bypass
    wire [`RCA_WIDTH-1:0] op_b = b_sel ? b_path : (a_sel ? {`RCA_WIDTH{1'b0}} : f_reg);
    wire [`RCA_WIDTH-1:0] op_a = (b_sel & ~a_sel) ? {`RCA_WIDTH{1'b0}} : a_path;

    rca_alu #(.WIDTH(`RCA_WIDTH)) u_alu (
        .op_a_in(op_a),
        .op_b_in(op_b),
        .fsel_in(fsel),
        .cin_in(cin),
        .f_out(alu_f),
        .zero_out(alu_zero),
        .cout_out(alu_cout),
        .ovf_out(alu_ovf),
        .g_n_out(alu_g_n),
        .p_n_out(alu_p_n)
    );

    rca_hold_reg #(.WIDTH(`RCA_WIDTH)) u_reg_f (
        .clk_in(CORE_CLK_IN),
        .load_n_in(cap_f_n),
        .d_in(alu_f),
        .q_out(f_reg)
    );

    // result pins are registered unless output bypass is set; flag pins always come straight from the alu
    assign RESULT_OUT = out_byp ? alu_f : f_reg;
    assign RESULT_OE_N_OUT = OUTPUT_DRIVE_N_IN;
    assign ZERO_FLAG_OUT = alu_zero;
    assign CARRY_OUT_OUT = alu_cout;
    assign OVERFLOW_FLAG_OUT = alu_ovf;
    assign GENERATE_N_OUT = alu_g_n;
    assign PROPAGATE_N_OUT = alu_p_n;

    // byte-lane merge for register writes
    function [`RCA_AXI_DW-1:0] merge_bytes;
        input [`RCA_AXI_DW-1:0] old_val;
        input [`RCA_AXI_DW-1:0] new_val;
        input [3:0] strb;
        integer k;
        begin
            merge_bytes = old_val;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
                end
            end
        end
    endfunction

    // write channel: address and data taken in either order, response after both
    wire aw_take = AWVALID_IN & AWREADY_OUT;
    wire w_take = WVALID_IN & WREADY_OUT;
    wire aw_full_d = aw_full_q | aw_take;
    wire w_full_d = w_full_q | w_take;
    wire do_write = aw_full_d & w_full_d;
    wire [`RCA_AXI_AW-1:0] wr_addr = aw_take ? AWADDR_IN : awaddr_q;
    wire [`RCA_AXI_DW-1:0] wr_data = w_take ? WDATA_IN : wdata_q;
    wire [3:0] wr_strb = w_take ? WSTRB_IN : wstrb_q;
    wire [`RCA_AXI_AW-1:0] wr_word = {wr_addr[`RCA_AXI_AW-1:2], 2'b00};
    wire bvalid_d = do_write | (BVALID_OUT & ~BREADY_IN);

    reg wr_ok;
    reg [`RCA_AXI_DW-1:0] ctrl_wide;
    always @* begin
        ctrl_wide = {{(`RCA_AXI_DW-`RCA_CTRL_W){1'b0}}, ctrl_q};
        if (wr_word == `RCA_OFF_CTRL) begin
            wr_ok = 1'b1;
        end else if (wr_word == `RCA_OFF_OPND) begin
            wr_ok = 1'b1;
        end else if (wr_word == `RCA_OFF_CAPT) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    wire [`RCA_AXI_DW-1:0] ctrl_new = merge_bytes(ctrl_wide, wr_data, wr_strb);

    always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= {`RCA_AXI_AW{1'b0}};
            wdata_q <= {`RCA_AXI_DW{1'b0}};
            wstrb_q <= 4'h0;
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= `RCA_RESP_OKAY;
            ctrl_q <= `RCA_CTRL_RESET;
            opnd_q <= `RCA_OPND_RESET;
            capt_q <= `RCA_CAPT_RESET;
        end else begin
            if (aw_take) begin
                awaddr_q <= AWADDR_IN;
            end
            if (w_take) begin
                wdata_q <= WDATA_IN;
                wstrb_q <= WSTRB_IN;
            end
            aw_full_q <= aw_full_d & ~do_write;
            w_full_q <= w_full_d & ~do_write;
            AWREADY_OUT <= ~bvalid_d & ~(aw_full_d & ~do_write);
            WREADY_OUT <= ~bvalid_d & ~(w_full_d & ~do_write);
            BVALID_OUT <= bvalid_d;
            // capture strobes last exactly one cycle
            capt_q <= `RCA_CAPT_RESET;
            if (do_write) begin
                BRESP_OUT <= wr_ok ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
                if (wr_word == `RCA_OFF_CTRL) begin
                    ctrl_q <= ctrl_new[`RCA_CTRL_W-1:0];
                end else if (wr_word == `RCA_OFF_OPND) begin
                    opnd_q <= merge_bytes(opnd_q, wr_data, wr_strb);
                end else if (wr_word == `RCA_OFF_CAPT) begin
                    if (wr_strb[0]) begin
                        capt_q <= wr_data[`RCA_CAPT_W-1:0];
                    end
                end
            end
        end
    end

    // read channel: one read in flight, data registered one cycle after the address
    wire ar_take = ARVALID_IN & ARREADY_OUT;
    wire rvalid_d = ar_take | (RVALID_OUT & ~RREADY_IN);
    wire [`RCA_AXI_AW-1:0] rd_word = {ARADDR_IN[`RCA_AXI_AW-1:2], 2'b00};

    reg [`RCA_AXI_DW-1:0] rd_data;
    reg rd_ok;
    always @* begin
        rd_data = {`RCA_AXI_DW{1'b0}};
        rd_ok = 1'b1;
        if (rd_word == `RCA_OFF_CTRL) begin
            rd_data[`RCA_CTRL_W-1:0] = ctrl_q;
        end else if (rd_word == `RCA_OFF_OPND) begin
            rd_data = opnd_q;
        end else if (rd_word == `RCA_OFF_CAPT) begin
            // strobes are write-only and read as zero
            rd_data = {`RCA_AXI_DW{1'b0}};
        end else if (rd_word == `RCA_OFF_STAT) begin
            // flags follow the live alu so software sees them without a capture
            rd_data[`RCA_STAT_F_MSB:`RCA_STAT_F_LSB] = f_reg;
            rd_data[`RCA_STAT_ZERO] = alu_zero;
            rd_data[`RCA_STAT_COUT] = alu_cout;
            rd_data[`RCA_STAT_OVF] = alu_ovf;
            rd_data[`RCA_STAT_GN] = alu_g_n;
            rd_data[`RCA_STAT_PN] = alu_p_n;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= {`RCA_AXI_DW{1'b0}};
            RRESP_OUT <= `RCA_RESP_OKAY;
        end else begin
            ARREADY_OUT <= ~rvalid_d;
            RVALID_OUT <= rvalid_d;
            if (ar_take) begin
                RDATA_OUT <= rd_data;
                RRESP_OUT <= rd_ok ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
            end
        end
    end

endmodule
`default_nettype wire

// File: rca_top_note_end.v
`timescale 1ns/1ps

// File: rca_top_checker.sv
// pin-level assertions for the registered cascadable alu
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.vh"
module rca_top_checker (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [15:0] A_IN,
    input wire logic [15:0] B_IN,
    input wire logic [2:0] FUNCTION_SELECT_IN,
    input wire logic CARRY_IN_IN,
    input wire logic A_OPERAND_SELECT_IN,
    input wire logic B_OPERAND_SELECT_IN,
    input wire logic OPERAND_A_CAPTURE_N_IN,
    input wire logic OPERAND_B_CAPTURE_N_IN,
    input wire logic RESULT_CAPTURE_N_IN,
    input wire logic INPUT_BYPASS_IN,
    input wire logic OUTPUT_BYPASS_IN,
    input wire logic OUTPUT_DRIVE_N_IN,
    input wire logic [15:0] RESULT_OUT,
    input wire logic RESULT_OE_N_OUT,
    input wire logic ZERO_FLAG_OUT,
    input wire logic CARRY_OUT_OUT,
    input wire logic OVERFLOW_FLAG_OUT,
    input wire logic GENERATE_N_OUT,
    input wire logic PROPAGATE_N_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // pin-to-pin path only: both bypasses on and both operands passed
    wire logic direct = INPUT_BYPASS_IN && OUTPUT_BYPASS_IN && A_OPERAND_SELECT_IN && B_OPERAND_SELECT_IN;
    wire logic [2:0] fs = FUNCTION_SELECT_IN;
    wire logic arith = (fs != `RCA_FN_CLEAR) && !fs[2];
    wire logic [15:0] opx = (fs == `RCA_FN_BMINA) ? ~A_IN : A_IN;
    wire logic [15:0] opy = (fs == `RCA_FN_AMINB) ? ~B_IN : B_IN;
    wire logic [16:0] sum17 = {1'b0, opx} + {1'b0, opy} + {16'h0000, CARRY_IN_IN};
    wire logic [15:0] low15 = {1'b0, opx[14:0]} + {1'b0, opy[14:0]} + {15'h0000, CARRY_IN_IN};
    wire logic [16:0] gsum = {1'b0, A_IN} + {1'b0, B_IN};
    wire logic [15:0] logic_res = (fs == `RCA_FN_XOR) ? (A_IN ^ B_IN) : (fs == `RCA_FN_OR) ? (A_IN | B_IN) :
                                  (fs == `RCA_FN_AND) ? (A_IN & B_IN) : 16'h0000;
    sequence reg_view;
        !OUTPUT_BYPASS_IN;
    endsequence
    sequence frozen;
        !INPUT_BYPASS_IN && OUTPUT_BYPASS_IN && A_OPERAND_SELECT_IN && B_OPERAND_SELECT_IN &&
        $stable(FUNCTION_SELECT_IN) && $stable(CARRY_IN_IN);
    endsequence
    chk_preset_ones: assert property (OUTPUT_BYPASS_IN && fs == `RCA_FN_PRESET |-> RESULT_OUT == 16'hffff)
        else $error("preset code did not give all ones");
    chk_zero_flag: assert property (OUTPUT_BYPASS_IN |-> ZERO_FLAG_OUT == (RESULT_OUT == 16'h0000))
        else $error("zero flag disagrees with alu result");
    chk_arith_sum: assert property (direct && arith |-> {CARRY_OUT_OUT, RESULT_OUT} == sum17)
        else $error("arithmetic result or carry wrong");
    chk_overflow_rule: assert property (direct && arith |-> OVERFLOW_FLAG_OUT == (low15[15] ^ sum17[16]))
        else $error("overflow flag wrong");
    chk_gen_prop: assert property (direct && fs == `RCA_FN_ADD |->
        PROPAGATE_N_OUT == ~&(A_IN | B_IN) && GENERATE_N_OUT == ~gsum[16])
        else $error("group generate or propagate wrong");
    chk_logic_ops: assert property (direct && !arith && fs != `RCA_FN_PRESET |-> RESULT_OUT == logic_res)
        else $error("logic or clear result wrong");
    chk_drive_follow: assert property (RESULT_OE_N_OUT == OUTPUT_DRIVE_N_IN)
        else $error("output drive enable wrong");
    chk_result_hold: assert property ((RESULT_CAPTURE_N_IN and reg_view) ##1 reg_view |-> $stable(RESULT_OUT))
        else $error("result register changed while not loading");
    chk_bypass_load: assert property ((!RESULT_CAPTURE_N_IN && OUTPUT_BYPASS_IN) ##1 reg_view |->
        RESULT_OUT == $past(RESULT_OUT))
        else $error("result register did not load under output bypass");
    chk_operand_hold: assert property (((OPERAND_A_CAPTURE_N_IN && OPERAND_B_CAPTURE_N_IN) and frozen) ##1 frozen |->
        $stable(RESULT_OUT))
        else $error("operand register changed while not loading");
    chk_force_zero: assert property (INPUT_BYPASS_IN && OUTPUT_BYPASS_IN && fs == `RCA_FN_ADD && !CARRY_IN_IN &&
        A_OPERAND_SELECT_IN != B_OPERAND_SELECT_IN |-> RESULT_OUT == (A_OPERAND_SELECT_IN ? A_IN : B_IN))
        else $error("operand force to zero wrong");
endmodule
bind rca_top rca_top_checker chk (.*);
`default_nettype wire

// File: rca_host_model.sv
// host sequencer model driving the alu operand and control pins
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.vh"
module rca_host_model (
    input wire logic clk_in,
    output logic [15:0] a_out,
    output logic [15:0] b_out,
    output logic [2:0] fsel_out,
    output logic [8:0] ctl_out
);
    // ctl_out: carry, b select, a select, a/b/result capture_n, in/out bypass, drive_n
    // starts with every register loading, since the datapath has no reset
    initial begin
        a_out = 16'h0000;
        b_out = 16'h0000;
        fsel_out = `RCA_FN_ADD;
        ctl_out = 9'h0c6;
    end
    // returns mid-cycle so callers look at settled outputs before the next capture edge
    task automatic step(input logic [15:0] a, input logic [15:0] b, input logic [2:0] f, input logic c,
                        input logic [1:0] sel, input logic [2:0] capn, input logic [1:0] byp, input logic drv_n);
        @(posedge clk_in);
        a_out <= a;
        b_out <= b;
        fsel_out <= f;
        ctl_out <= {c, sel, capn, byp, drv_n};
        @(negedge clk_in);
    endtask
    task automatic preload(input logic [15:0] a);
        step(a, 16'h5555, `RCA_FN_ADD, 1'b0, 2'b01, 3'b110, 2'b11, 1'b0);
    endtask
    task automatic clear_acc;
        step(16'h5555, 16'h5555, `RCA_FN_CLEAR, 1'b0, 2'b00, 3'b110, 2'b10, 1'b0);
    endtask
    task automatic subtract(input logic [15:0] a, input logic [15:0] b, input logic a_minus_b);
        step(a, b, a_minus_b ? `RCA_FN_AMINB : `RCA_FN_BMINA, 1'b1, 2'b11, 3'b000, 2'b11, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: test_registered_cascadable_alu16.sv
// self-checking bench for the registered cascadable alu
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.vh"
module test_registered_cascadable_alu16;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] a, b;
    logic [2:0] fsel;
    logic [8:0] ctl;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0;
    logic [2:0] prot = 3'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire logic [15:0] res;
    wire logic [31:0] rdata;
    wire logic [1:0] bresp, rresp;
    wire logic oe_n, zf, co, ovf, gn, pn, awready, wready, bvalid, arready, rvalid;
    wire logic [15:0] result_bus;
    int error_cnt = 0;
    int n_compared = 0;
    assign result_bus = oe_n ? 16'hzzzz : res;
    always #20 clk = ~clk;
    rca_host_model host (.clk_in(clk), .a_out(a), .b_out(b), .fsel_out(fsel), .ctl_out(ctl));
    rca_top DUT (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .A_IN(a), .B_IN(b), .FUNCTION_SELECT_IN(fsel),
        .CARRY_IN_IN(ctl[8]), .B_OPERAND_SELECT_IN(ctl[7]), .A_OPERAND_SELECT_IN(ctl[6]),
        .OPERAND_A_CAPTURE_N_IN(ctl[5]), .OPERAND_B_CAPTURE_N_IN(ctl[4]), .RESULT_CAPTURE_N_IN(ctl[3]),
        .INPUT_BYPASS_IN(ctl[2]), .OUTPUT_BYPASS_IN(ctl[1]), .OUTPUT_DRIVE_N_IN(ctl[0]), .RESULT_OUT(res),
        .RESULT_OE_N_OUT(oe_n), .ZERO_FLAG_OUT(zf), .CARRY_OUT_OUT(co), .OVERFLOW_FLAG_OUT(ovf),
        .GENERATE_N_OUT(gn), .PROPAGATE_N_OUT(pn), .AWADDR_IN(awaddr), .AWPROT_IN(prot), .AWVALID_IN(awvalid),
        .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
        .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARPROT_IN(prot),
        .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready));
    task automatic tally_and_finish;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // expected {generate_n, propagate_n, overflow, carry, result}
    function automatic logic [19:0] model(input logic [15:0] x0, input logic [15:0] y0, input logic [2:0] f,
                                          input logic c);
        logic [15:0] x, y, lo, r;
        logic [16:0] s, g;
        x = (f == `RCA_FN_BMINA) ? ~x0 : x0;
        y = (f == `RCA_FN_AMINB) ? ~y0 : y0;
        s = {1'b0, x} + {1'b0, y} + {16'h0000, c};
        g = {1'b0, x} + {1'b0, y};
        lo = {1'b0, x[14:0]} + {1'b0, y[14:0]} + {15'h0000, c};
        case (f)
            `RCA_FN_CLEAR: r = 16'h0000;
            `RCA_FN_XOR: r = x0 ^ y0;
            `RCA_FN_OR: r = x0 | y0;
            `RCA_FN_AND: r = x0 & y0;
            `RCA_FN_PRESET: r = 16'hffff;
            default: r = s[15:0];
        endcase
        return {~g[16], ~&(x | y), lo[15] ^ s[16], s[16], r};
    endfunction
    task automatic check_alu(input logic [15:0] x, input logic [15:0] y, input logic [2:0] f, input logic c);
        logic [19:0] e;
        e = model(x, y, f, c);
        cmp({16'h0, res}, {16'h0, e[15:0]}, "alu result");
        cmp({31'h0, zf}, {31'h0, e[15:0] == 16'h0000}, "zero flag");
        if (f != `RCA_FN_CLEAR && !f[2]) cmp({28'h0, gn, pn, ovf, co}, {28'h0, e[19:16]}, "status");
    endtask
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        cmp({29'h0, bvalid, bresp}, {29'h1, er}, "write response");
    endtask
    task automatic axi_rd(input logic [3:0] ad, input logic [31:0] mask, input logic [31:0] ed);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        cmp({rdata & mask}, ed, "read data");
        cmp({30'h0, rresp}, {30'h0, `RCA_RESP_OKAY}, "read response");
    endtask
    task automatic op(input logic [15:0] x, input logic [15:0] y, input logic [2:0] f, input logic c);
        host.step(x, y, f, c, 2'b11, 3'b000, 2'b11, 1'b0);
        check_alu(x, y, f, c);
    endtask
    task automatic t_functions;
        for (int f = 0; f < 8; f++) op(16'hf0c3, 16'h5a0f, f[2:0], 1'b1);
        op(16'h3c3c, 16'h3c3c, `RCA_FN_XOR, 1'b0);
        op(16'h7fff, 16'h0001, `RCA_FN_ADD, 1'b0);
        op(16'hffff, 16'h0001, `RCA_FN_ADD, 1'b0);
        op(16'h0000, 16'h0000, `RCA_FN_ADD, co);
        cmp({16'h0, res}, 32'd1, "upper slice carry");
        host.subtract(16'h0005, 16'h0007, 1'b1);
        check_alu(16'h0005, 16'h0007, `RCA_FN_AMINB, 1'b1);
        host.subtract(16'h8000, 16'h0001, 1'b0);
        check_alu(16'h8000, 16'h0001, `RCA_FN_BMINA, 1'b1);
    endtask
    task automatic t_operand_regs;
        host.step(16'd3, 16'd4, `RCA_FN_ADD, 1'b0, 2'b11, 3'b001, 2'b01, 1'b0);
        host.step(16'd9, 16'd9, `RCA_FN_ADD, 1'b0, 2'b11, 3'b111, 2'b01, 1'b0);
        cmp({16'h0, res}, 32'd7, "registered operands");
        host.step(16'd8, 16'd8, `RCA_FN_ADD, 1'b0, 2'b11, 3'b011, 2'b11, 1'b0);
        cmp({16'h0, res}, 32'd16, "input bypass");
        host.step(16'd2, 16'd2, `RCA_FN_ADD, 1'b0, 2'b11, 3'b111, 2'b01, 1'b0);
        cmp({16'h0, res}, 32'd12, "a loaded in bypass, b held");
    endtask
    task automatic t_accumulate;
        host.preload(16'd100);
        cmp({16'h0, res}, 32'd100, "preload path");
        host.step(16'd5, 16'h5555, `RCA_FN_ADD, 1'b0, 2'b00, 3'b110, 2'b11, 1'b0);
        cmp({16'h0, res}, 32'd105, "feedback under output bypass");
        host.step(16'd5, 16'h5555, `RCA_FN_ADD, 1'b0, 2'b00, 3'b110, 2'b10, 1'b0);
        cmp({16'h0, res}, 32'd105, "result register view");
        host.clear_acc();
        cmp({16'h0, res}, 32'd110, "accumulated");
        host.step(16'd5, 16'h5555, `RCA_FN_ADD, 1'b0, 2'b00, 3'b111, 2'b10, 1'b0);
        cmp({16'h0, res}, 32'd0, "cleared");
        axi_rd(`RCA_OFF_STAT, 32'h0000_ffff, 32'h0);
        host.step(16'd5, 16'h5555, `RCA_FN_ADD, 1'b0, 2'b00, 3'b111, 2'b10, 1'b1);
        cmp({16'h0, result_bus}, {16'h0, 16'hzzzz}, "released pins");
    endtask
    task automatic t_registers;
        axi_rd(`RCA_OFF_CTRL, 32'hffff_ffff, 32'h0000_0018);
        axi_wr(`RCA_OFF_CTRL, 32'h0000_01ff, 4'h1, `RCA_RESP_OKAY);
        axi_rd(`RCA_OFF_CTRL, 32'hffff_ffff, 32'h0000_00ff);
        axi_wr(`RCA_OFF_CTRL, 32'h0000_0018, 4'hf, `RCA_RESP_OKAY);
        axi_wr(`RCA_OFF_OPND, 32'h1234_abcd, 4'hf, `RCA_RESP_OKAY);
        axi_rd(`RCA_OFF_OPND, 32'hffff_ffff, 32'h1234_abcd);
        axi_wr(`RCA_OFF_STAT, 32'hffff_ffff, 4'hf, `RCA_RESP_SLVERR);
        axi_wr(`RCA_OFF_CAPT, 32'h0000_0007, 4'hf, `RCA_RESP_OKAY);
        axi_rd(`RCA_OFF_CAPT, 32'hffff_ffff, 32'h0);
        cmp({16'h0, res}, 32'd0, "pin mode result kept");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_functions();
        t_operand_regs();
        t_accumulate();
        t_registers();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("mismatch at %0t: run did not complete", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
